/* design/ctsc_clock_timing_standby_ctrl.sv */
`timescale 1ns/1ps
`include "ctsc_consts.svh"
module ctsc_clock_timing_standby_ctrl
  import ctsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Release pin and interrupt sources
  input wire logic release_pin,
  input wire logic [15:0] irq_request,
  input wire logic [15:0] irq_accept,
  // Clocks and control out
  output logic sys_clk_ff_o,
  output logic [1:0] mc_state,
  output logic mc_last,
  output logic [20:0] divider_taps,
  output logic osc_enable,
  output logic cpu_run,
  output logic wdt_run,
  output logic periph_run,
  output logic port_hiz,
  output logic [15:0] irq_pending_latch_o,
  output logic irq_service_req
);

  // Register file
  logic [7:0] system_control_one_ff;
  logic idle_req_ff;
  logic master_irq_enable_ff;
  logic [15:0] per_source_irq_enable_ff;
  logic [15:0] irq_pending_latch_ff;
  logic halt_release_method_sel_eff_ff;
  logic pin_prev_ff;
  ctsc_mode_t mode_ff;
  logic [`CTSC_PRE_W-1:0] pre_ff;
  logic [`CTSC_DIV_W-1:0] div_ff;
  logic [1:0] state_ff;
  logic [3:0] mc_cnt_ff;
  logic [3:0] mc_len_ff;
  logic [31:0] prdata_ff;
  logic sys_ff;

  logic wr;
  logic rd;
  logic stop_wr;
  logic idle_wr;
  logic pin_rise;
  logic wake_irq;
  logic pre_tick;
  logic [`CTSC_DIV_W-1:0] warm_end;
  logic [15:0] nxt_pending;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign stop_wr = wr && paddr == `CTSC_OFF_SYSCTL1 &&
                   pwdata[`CTSC_BIT_STOP];
  assign idle_wr = wr && paddr == `CTSC_OFF_SYSCTL2 &&
                   pwdata[`CTSC_BIT_IDLE];
  assign pin_rise = release_pin && !pin_prev_ff;
  // Any individually enabled latch wakes idle, master flag irrelevant
  assign wake_irq = |(irq_pending_latch_ff & per_source_irq_enable_ff);
  assign pre_tick = pre_ff == `CTSC_PRE_W'(3);
  assign warm_end = system_control_one_ff[`CTSC_BIT_WUT_LO] ?
                    `CTSC_WARM_SHORT : `CTSC_WARM_LONG;

  // Prescaler never cleared except by power-on reset state
  // Keeping its phase across stop exit means the first system clock
  // after warm-up may be short; the divider still restarts from zero
  always_ff @(posedge clk) begin
    if (!rst_n && pre_ff === 2'bxx) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + `CTSC_PRE_W'(1);
    end
  end

  // Divider on basic clock; cleared on reset, stop, warm-up end
  // In normal and idle it steps once per prescaler wrap; in warm-up it
  // steps every basic clock, so a warm-up entered from stop runs the exact selected count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (mode_ff == CTSC_STOP) begin
      div_ff <= '0;
    end else if (mode_ff == CTSC_WARMUP) begin
      // Counts every basic clock so duration from stop is exact
      div_ff <= (div_ff == warm_end - 21'h1) ? '0 : div_ff + 21'h1;
    end else if (pre_tick) begin
      div_ff <= div_ff + 21'h1;
    end
  end

  // Mode machine
  // Normal leaves on a stop write, or on an idle write while latch 2 is clear; stop write wins if both came
  // Idle returns on any enabled pending latch, whatever the master flag
  // Stop leaves only through warm-up, warm-up only to normal
  // Reset overrides every mode, so no warm-up follows a reset in stop
  // The default branch recovers an impossible code into normal mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= CTSC_NORMAL;
    end else begin
      case (mode_ff)
        CTSC_NORMAL: begin
          if (stop_wr) begin
            // Level mode with pin high goes straight to warm-up
            if (halt_release_method_sel_eff_ff && release_pin) begin
              mode_ff <= CTSC_WARMUP;
            end else begin
              mode_ff <= CTSC_STOP;
            end
          end else if (idle_wr && !irq_pending_latch_ff[2]) begin
            mode_ff <= CTSC_IDLE;
          end
        end
        CTSC_IDLE: begin
          if (wake_irq) begin
            mode_ff <= CTSC_NORMAL;
          end
        end
        CTSC_STOP: begin
          if (halt_release_method_sel_eff_ff ? release_pin : pin_rise) begin
            mode_ff <= CTSC_WARMUP;
          end
        end
        CTSC_WARMUP: begin
          // Pin level ignored here, no way back to stop
          if (div_ff == warm_end - 21'h1) begin
            mode_ff <= CTSC_NORMAL;
          end
        end
        default: mode_ff <= CTSC_NORMAL;
      endcase
    end
  end

  // Pin edge history
  // Reset value matches the pin's usual idle low, so no false edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= release_pin;
    end
  end

  // Effective release method lags an edge-to-level change
  // A plain copy of the select bit would let a level release fire early
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_release_method_sel_eff_ff <= 1'b0;
    end else if (!system_control_one_ff[`CTSC_BIT_HALT_RELEASE_METHOD_SEL]) begin
      halt_release_method_sel_eff_ff <= 1'b0;
    end else if (pin_rise) begin
      halt_release_method_sel_eff_ff <= 1'b1;
    end
  end

  // First control register; stop bit never stored, so it self-clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      system_control_one_ff <= 8'h00;
    end else if (wr && paddr == `CTSC_OFF_SYSCTL1) begin
      system_control_one_ff <= {1'b0, pwdata[6:0]};
    end
  end

  // Idle bit reads back the live mode, as idle keeps no stored request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_req_ff <= 1'b0;
    end else begin
      idle_req_ff <= mode_ff == CTSC_IDLE;
    end
  end

  // Master enable: software writes it, acceptance clears it
  // A write in the acceptance cycle wins, as it is the newer intent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_irq_enable_ff <= 1'b0;
    end else if (wr && paddr == `CTSC_OFF_IRQ_EN) begin
      master_irq_enable_ff <= pwdata[`CTSC_BIT_IMF];
    end else if (irq_accept != 16'h0000) begin
      master_irq_enable_ff <= 1'b0;
    end
  end

  // Per-source enables; bit 0 position belongs to the master flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_source_irq_enable_ff <= 16'h0000;
    end else if (wr && paddr == `CTSC_OFF_IRQ_EN) begin
      per_source_irq_enable_ff <= {pwdata[15:1], 1'b0};
    end
  end

  // Pending latches: set wins over acceptance and software clear
  // Software may only clear latches; a zero bit in the write clears
  // A request in the clearing cycle survives, so no request is lost
  always_comb begin
    nxt_pending = irq_pending_latch_ff & ~irq_accept;
    if (wr && paddr == `CTSC_OFF_IRQ_PEND) begin
      nxt_pending = nxt_pending & pwdata[15:0];
    end
    nxt_pending = nxt_pending | irq_request;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pending_latch_ff <= 16'h0000;
    end else begin
      irq_pending_latch_ff <= nxt_pending;
    end
  end

  // Machine cycle: four states of half a system clock each
  // The cycle counter halts with the CPU clock in stop and warm-up
  // Length register holds the longest instruction; every count runs up to it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= 2'h0;
      mc_cnt_ff <= `CTSC_MC_MIN;
      mc_len_ff <= `CTSC_MC_MAX;
      sys_ff <= 1'b0;
    end else if (mode_ff != CTSC_STOP && mode_ff != CTSC_WARMUP &&
                 pre_tick) begin
      sys_ff <= ~sys_ff;
      state_ff <= state_ff + 2'h1;
      if (state_ff == `CTSC_STATE_LAST) begin
        // Wraps after the longest instruction length
        mc_cnt_ff <= (mc_cnt_ff == mc_len_ff) ? `CTSC_MC_MIN :
                     mc_cnt_ff + 4'h1;
      end
    end
  end

  // Oscillator is off only in stop; warm-up already has it running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= mode_ff != CTSC_STOP;
    end
  end

  // CPU and watchdog run only in normal; both halt in idle and warm-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_run <= 1'b1;
      wdt_run <= 1'b1;
    end else begin
      cpu_run <= mode_ff == CTSC_NORMAL;
      wdt_run <= mode_ff == CTSC_NORMAL;
    end
  end

  // Peripherals keep their clock in idle, lose it in stop and warm-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periph_run <= 1'b1;
    end else begin
      periph_run <= mode_ff == CTSC_NORMAL || mode_ff == CTSC_IDLE;
    end
  end

  // Ports float in stop only while the hold option is off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_hiz <= 1'b0;
    end else begin
      port_hiz <= mode_ff == CTSC_STOP &&
                  !system_control_one_ff[`CTSC_BIT_PORT_DRIVE_IN_HALT_SEL];
    end
  end

  // Service request waits out stop; a latch set there is served after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_service_req <= 1'b0;
    end else begin
      irq_service_req <= master_irq_enable_ff && wake_irq &&
                         mode_ff != CTSC_STOP;
    end
  end

  // Outputs from flops
  // Registering every status keeps the top outputs glitch-free,
  // at the cost of one cycle of lag behind the internal state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_clk_ff_o <= 1'b0;
      mc_state <= 2'h0;
      mc_last <= 1'b0;
      divider_taps <= '0;
      irq_pending_latch_o <= 16'h0000;
    end else begin
      sys_clk_ff_o <= sys_ff;
      mc_state <= state_ff;
      mc_last <= state_ff == `CTSC_STATE_LAST;
      divider_taps <= div_ff;
      irq_pending_latch_o <= irq_pending_latch_ff;
    end
  end

  // APB read data, registered in the setup cycle
  // Data is ready by the access cycle, so no wait state is ever added
  // Unmapped reads return zero alongside the error response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0;
    end else if (rd) begin
      case (paddr)
        `CTSC_OFF_SYSCTL1: prdata_ff <= {24'h0, system_control_one_ff};
        `CTSC_OFF_SYSCTL2: prdata_ff <= {27'h0, idle_req_ff, 4'h0};
        `CTSC_OFF_IRQ_EN: prdata_ff <= {16'h0, per_source_irq_enable_ff[15:1],
                                       master_irq_enable_ff};
        `CTSC_OFF_IRQ_PEND: prdata_ff <= {16'h0, irq_pending_latch_ff};
        `CTSC_OFF_STATUS: prdata_ff <= {28'h0, halt_release_method_sel_eff_ff, 1'b0, mode_ff};
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

  // Always ready; error on unmapped address
  // Writes to unmapped offsets fall through every decode and are lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != `CTSC_OFF_SYSCTL1 &&
                 paddr != `CTSC_OFF_SYSCTL2 && paddr != `CTSC_OFF_IRQ_EN &&
                 paddr != `CTSC_OFF_IRQ_PEND && paddr != `CTSC_OFF_STATUS;
    end
  end

  assign prdata = prdata_ff;

endmodule

/* design/ctsc_consts.svh */
`ifndef CTSC_CONSTS_SVH
`define CTSC_CONSTS_SVH
// APB register byte offsets
`define CTSC_OFF_SYSCTL1 12'h000
`define CTSC_OFF_SYSCTL2 12'h004
// Enable register sits at word index 3a, byte address four times it
`define CTSC_IDX_IRQ_EN 10'h03a
`define CTSC_OFF_IRQ_EN {`CTSC_IDX_IRQ_EN, 2'b00}
`define CTSC_OFF_IRQ_PEND 12'h00c
`define CTSC_OFF_STATUS 12'h010
// Field positions
`define CTSC_BIT_STOP 7
`define CTSC_BIT_HALT_RELEASE_METHOD_SEL 6
`define CTSC_BIT_PORT_DRIVE_IN_HALT_SEL 4
`define CTSC_BIT_WUT_LO 2
`define CTSC_BIT_WUT_HI 3
`define CTSC_BIT_IDLE 4
`define CTSC_BIT_IMF 0
// Widths and counts
`define CTSC_PRE_W 2
`define CTSC_DIV_W 21
`define CTSC_WARM_LONG 21'h180000
`define CTSC_WARM_SHORT 21'h080000
`define CTSC_STATE_LAST 2'h3
`define CTSC_MC_MAX 4'ha
`define CTSC_MC_MIN 4'h1
`endif

/* design/ctsc_pkg.sv */
package ctsc_pkg;
  typedef enum logic [1:0] {
    CTSC_NORMAL,
    CTSC_IDLE,
    CTSC_STOP,
    CTSC_WARMUP
  } ctsc_mode_t;
endpackage

/* tb/ctsc_far_model.sv */
`timescale 1ns/1ps
module ctsc_far_model (
  // Clock and bench control
  input wire logic clk,
  input wire logic acc_en,
  // From the block
  input wire logic irq_service_req,
  input wire logic [15:0] irq_pending_latch_o,
  // Toward the block
  output logic release_pin,
  output logic [15:0] irq_request,
  output logic [15:0] irq_accept
);
  initial begin
    release_pin = 1'h0;
    irq_request = 16'h0;
    irq_accept = 16'h0;
  end
  // Pin level changes land just after an edge
  task automatic pin(input logic v);
    @(posedge clk);
    release_pin <= v;
  endtask
  // One-cycle request pulse from one source
  task automatic req(input int i);
    @(posedge clk);
    irq_request[i] <= 1'h1;
    @(posedge clk);
    irq_request[i] <= 1'h0;
  endtask
  // CPU takes the highest-priority pending source; one-cycle pulses, never two in a row
  always @(posedge clk) begin
    if (acc_en && irq_service_req && irq_accept == 16'h0) begin
      irq_accept <= irq_pending_latch_o & (~irq_pending_latch_o + 16'h1);
    end else begin
      irq_accept <= 16'h0;
    end
  end
endmodule

/* tb/ctsc_monitor.sv */
`timescale 1ns/1ps
module ctsc_monitor (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Requests and block state
  input wire logic [15:0] irq_request,
  input wire logic [15:0] irq_accept,
  input wire logic [15:0] irq_pending_latch_o,
  input wire logic [1:0] mc_state,
  input wire logic mc_last,
  input wire logic [20:0] divider_taps,
  input wire logic osc_enable,
  input wire logic cpu_run,
  input wire logic wdt_run,
  input wire logic periph_run,
  input wire logic port_hiz
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Completing write that sets one bit of one register
  sequence s_wr(logic [11:0] a, int b);
    psel && penable && pwrite && paddr == a && pwdata[b];
  endsequence
  // Quiet request lines, so nothing can end idle at once
  sequence s_quiet;
    irq_request == 16'h0 && irq_pending_latch_o == 16'h0;
  endsequence
  // Mode change shows on the run outputs two edges after the write
  stop_entry_a: assert property (
    s_wr(12'h000, 7) ##0 cpu_run |-> ##2 !cpu_run)
    else $error("stop write left cpu running");
  idle_entry_a: assert property (
    s_wr(12'h004, 4) ##0 cpu_run ##0 s_quiet |-> ##2 !cpu_run && periph_run)
    else $error("idle not entered");
  idle_keep_a: assert property (
    periph_run && !cpu_run |-> osc_enable && !wdt_run)
    else $error("idle state wrong");
  normal_run_a: assert property (
    cpu_run |-> wdt_run && periph_run && osc_enable)
    else $error("normal state wrong");
  // Divider output lags the oscillator flag by one cycle
  stop_halt_a: assert property (
    !osc_enable && !$past(osc_enable)
    |-> !periph_run && !cpu_run && divider_taps == 21'h0)
    else $error("stop does not halt");
  hiz_stop_a: assert property (port_hiz |-> !osc_enable)
    else $error("ports floated outside stop");
  warm_first_a: assert property ($rose(osc_enable) |-> !cpu_run)
    else $error("resume without warm-up");
  mc_last_a: assert property (mc_last == (mc_state == 2'h3))
    else $error("last-state flag wrong");
  mc_step_a: assert property (
    cpu_run && $past(cpu_run) && $changed(mc_state)
    |-> mc_state == $past(mc_state) + 2'h1) else $error("state skipped");
  accept_clear_a: assert property (
    irq_accept[4] && !irq_request[4] |-> ##2 !irq_pending_latch_o[4])
    else $error("latch kept after accept");
endmodule
bind ctsc_clock_timing_standby_ctrl ctsc_monitor mon (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .irq_request(irq_request), .irq_accept(irq_accept),
  .irq_pending_latch_o(irq_pending_latch_o), .mc_state(mc_state),
  .mc_last(mc_last), .divider_taps(divider_taps),
  .osc_enable(osc_enable), .cpu_run(cpu_run), .wdt_run(wdt_run),
  .periph_run(periph_run), .port_hiz(port_hiz)
);

/* tb/tb.sv */
`timescale 1ns/1ps
module tb import ctsc_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, acc_en, pready, pslverr;
  logic release_pin, svc, sys_clk, mc_last, sc;
  logic [1:0] mc_state, s0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] irq_request, irq_accept, lat;
  logic [20:0] div;
  logic osc_enable, cpu_run, wdt_run, periph_run, port_hiz, rerr;
  int n_errors = 0, samples_checked = 0;
  wire [3:0] run4 = {osc_enable, cpu_run, wdt_run, periph_run};
  always #20 clk = ~clk;
  ctsc_clock_timing_standby_ctrl uut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .release_pin(release_pin), .irq_request(irq_request),
    .irq_accept(irq_accept), .sys_clk_ff_o(sys_clk), .mc_state(mc_state),
    .mc_last(mc_last), .divider_taps(div), .osc_enable(osc_enable),
    .cpu_run(cpu_run), .wdt_run(wdt_run), .periph_run(periph_run),
    .port_hiz(port_hiz),
    .irq_pending_latch_o(lat), .irq_service_req(svc));
  ctsc_far_model far (.clk(clk), .acc_en(acc_en), .irq_service_req(svc),
    .irq_pending_latch_o(lat), .release_pin(release_pin),
    .irq_request(irq_request), .irq_accept(irq_accept));
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  // Ends just past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Hang guard, well beyond the couple of hundred cycles the tests need
  initial begin
    wt(20000);
    n_errors++;
    end_of_test();
  end
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    acc_en = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst();
    rd(12'h0e8, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // One prescaler wrap in four basic clocks steps state and clock
    s0 = mc_state;
    sc = sys_clk;
    wt(4);
    chk(mc_state, 2'(s0 + 2'h1));
    chk(sys_clk, !sc);
    chk(mc_last, mc_state == 2'h3);
    apb(1'h1, 12'h0e8, 32'h10);
    rd(12'h0e8, 32'h10);
    apb(1'h1, 12'h004, 32'h10);
    rd(12'h010, {30'h0, CTSC_IDLE});
    chk(run4, 4'h9);
    far.req(4);
    wt(4);
    chk(run4, 4'hf);
    rd(12'h00c, 32'h10);
    apb(1'h1, 12'h00c, 32'h0);
    acc_en <= 1'h1;
    apb(1'h1, 12'h0e8, 32'h11);
    apb(1'h1, 12'h004, 32'h10);
    far.req(4);
    wt(6);
    chk(run4, 4'hf);
    rd(12'h00c, 32'h0);
    acc_en <= 1'h0;
    apb(1'h1, 12'h0e8, 32'h0);
    far.req(2);
    apb(1'h1, 12'h004, 32'h10);
    wt(2);
    chk(run4, 4'hf);
    apb(1'h1, 12'h00c, 32'h0);
    // Edge release: pin already high must not block entry
    far.pin(1'h1);
    apb(1'h1, 12'h000, 32'h80);
    wt(2);
    chk(run4, 4'h0);
    chk({div, port_hiz}, {21'h0, 1'h1});
    far.pin(1'h0);
    far.pin(1'h1);
    wt(2);
    chk(run4, 4'h8);
    rst();
    far.pin(1'h0);
    apb(1'h1, 12'h000, 32'h90);
    wt(2);
    chk({run4, port_hiz}, 5'h00);
    rst();
    chk(run4, 4'hf);
    // Level release only takes effect after a rising pin edge
    apb(1'h1, 12'h000, 32'h40);
    rd(12'h010, 32'h0);
    far.pin(1'h1);
    rd(12'h010, 32'h8);
    apb(1'h1, 12'h000, 32'hc0);
    wt(2);
    chk(run4, 4'h8);
    far.pin(1'h0);
    wt(8);
    chk(run4, 4'h8);
    rst();
    chk(run4, 4'hf);
    end_of_test();
  end
endmodule
